// ==== sysctl_pkg.sv ====
// sysctl_pkg: register map, field positions, reset values and timing
// for the system control and digital line block.
// assumes a 16-bit serial frame and a 125 MHz core clock.
package sysctl_pkg;

    // core clock rate, used to turn times into cycle counts
    localparam int unsigned CLK_MHZ = 125;

    // register byte offsets (each register spans an even/odd byte pair)
    localparam logic [6:0] OFS_FLASH_WRITE_COUNTER  = 7'h00;
    localparam logic [6:0] OFS_ALARM_CTRL = 7'h18;
    localparam logic [6:0] OFS_GIO_CTRL   = 7'h1a;
    localparam logic [6:0] OFS_MISC_CTRL  = 7'h1c;
    localparam logic [6:0] OFS_SLEEP_CTRL = 7'h24;
    localparam logic [6:0] OFS_ERR_FLAGS  = 7'h26;
    localparam logic [6:0] OFS_GLOBAL_COMMAND   = 7'h28;
    localparam logic [6:0] OFS_LOT_ONE    = 7'h32;
    localparam logic [6:0] OFS_LOT_TWO    = 7'h34;
    localparam logic [6:0] OFS_LOT_THREE  = 7'h36;
    localparam logic [6:0] OFS_PART_CODE  = 7'h38;
    localparam logic [6:0] OFS_SERIAL     = 7'h3a;

    // global command trigger bits
    localparam int GC_SW_RESET = 7;
    localparam int GC_FLASH    = 3;
    localparam int GC_RESTORE  = 1;
    localparam int GC_BIAS     = 0;
    localparam logic [15:0] GC_MASK = 16'h008b;

    // misc control fields
    localparam int MC_MEM_TEST  = 11;
    localparam int MC_SELF_TEST = 10;
    localparam int MC_BYPASS    = 7;
    localparam int MC_DR_EN     = 2;
    localparam int MC_DR_POL    = 1;
    localparam int MC_DR_SEL    = 0;
    localparam logic [15:0] MC_MASK  = 16'h0c87;
    localparam logic [15:0] MC_RESET = 16'h0006;

    // alarm control indicator fields (same layout as data ready)
    localparam int AC_EN  = 2;
    localparam int AC_POL = 1;
    localparam int AC_SEL = 0;
    localparam logic [15:0] AC_MASK = 16'h0007;

    // general-purpose register: levels in 11:8, directions in 3:0
    localparam int          GIO_LVL  = 8;
    localparam int          GIO_DIR  = 0;
    localparam logic [15:0] GIO_MASK = 16'h0f0f;
    localparam logic [15:0] GIO_RESET = 16'h0000;

    // sleep control keeps its low byte only
    localparam logic [15:0] SLP_MASK = 16'h00ff;

    // error flag positions
    localparam int EF_ALARM2    = 9;
    localparam int EF_ALARM1    = 8;
    localparam int EF_CHECKSUM  = 6;
    localparam int EF_SELF_TEST = 5;
    localparam int EF_OVERRANGE = 4;
    localparam int EF_FLASH     = 2;

    // data ready pulse: between 100 us and 200 us
    localparam int unsigned DRDY_MIN_US  = 100;
    localparam int unsigned DRDY_MAX_US  = 200;
    localparam int unsigned DRDY_CYCLES  = DRDY_MIN_US * CLK_MHZ;

    // modelled duration of a command or a test
    localparam int unsigned CMD_CYCLES  = 16;
    localparam int unsigned TEST_CYCLES = 64;

    // one serial frame: write flag, byte address, data byte
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } spi_frame_t;

endpackage

// ==== spi_link_slave.sv ====
// spi_link_slave: 16-bit serial frame shifter on the link clock.
// assumes sclk idles high, data sampled on rising and driven on falling
// edges; tx_word stays steady while a frame is in flight.
`timescale 1ns/1ns
module spi_link_slave (
    input  wire logic        sclk,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        mosi,
    input  wire logic [15:0] tx_word,
    output logic             miso,
    output logic             miso_oe,
    output logic [15:0]      rx_word,
    output logic             rx_toggle
);

    logic [3:0]  bit_cnt_q;  // rising edges seen in this frame
    logic [14:0] shift_q;    // bits received so far

    // bit counter, cleared whenever the select is high; reset as well, so
    // the first frame after power-up does not hang on a select edge
    always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 4'h0;
        end else if (cs_n) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // receive shifter, msb first
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 15'h0000;
        end else begin
            shift_q <= {shift_q[13:0], mosi};
        end
    end

    // whole frame: hold the word and flip the toggle for the core side
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_word   <= 16'h0000;
            rx_toggle <= 1'b0;
        end else if (bit_cnt_q == 4'hf) begin
            rx_word   <= {shift_q, mosi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // answer bits go out on falling edges, msb first
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            miso <= 1'b0;
        end else begin
            miso <= tx_word[4'hf - bit_cnt_q];
        end
    end

    // drive the data line only inside a frame
    always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
        if (!rst_n) begin
            miso_oe <= 1'b0;
        end else if (cs_n) begin
            miso_oe <= 1'b0;
        end else begin
            miso_oe <= 1'b1;
        end
    end

endmodule // spi_link_slave

// ==== system_control_gpio.sv ====
// system_control_gpio: system registers, command triggers, flash write
// counter, checksum and self test triggers, digital line multiplexing.
// assumes sensor-side status inputs are on clk; serial port on sclk.
`timescale 1ns/1ns

// Contract
// - command triggers self-clear after their function
// - bit 7 software reset reloads stored registers
// - command bits 7,3,1,0 only; reset zero
// - flash, restore, bias commands write flash
// - 16-bit counter counts every flash write
// - misc bit 11 checksum; flag bit 6
// - checksum trigger clears itself when done
// - data ready beats alarm beats general I/O
// - unclaimed lines and lines 3,4 are general
// - misc bits 2:0 data ready enable/polarity/line
// - misc control resets to 0x0006
// - data ready pulse 100 to 200 us
// - misc bit 7 bypasses compensation
// - levels in bits 11:8, pins read back; output lines read the set level instead
// - direction bits, one means output
// - misc bit 10 self test; flag bit 5
// - reading error flags clears them
// - alarm bits 2:0 enable/polarity/line
// - factory restore ends in a flash write
module system_control_gpio #(
    parameter int unsigned DRDY_LEN   = sysctl_pkg::DRDY_CYCLES, // pulse length
    parameter logic [15:0] PART_VALUE = 16'h1234, // arbitrary value
    parameter logic [15:0] LOT_VALUE  = 16'h0000, // arbitrary value
    parameter logic [15:0] SER_VALUE  = 16'h0001  // arbitrary value
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    input  wire logic [3:0] dio_in,
    output logic [3:0]      dio_out,
    output logic [3:0]      dio_oe,
    input  wire logic       sample_tick,
    input  wire logic       alarm_active,
    input  wire logic [1:0] alarm_status,
    input  wire logic       over_range,
    input  wire logic       flash_bad,
    input  wire logic       checksum_bad,
    input  wire logic       self_test_bad,
    output logic            comp_bypass,
    output logic            self_test_drive,
    output logic            flash_write,
    output logic            data_clear
);

    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_TEST} eng_t;

    // register bank
    logic [15:0] gio_q, misc_q, alarm_q, sleep_q, glob_q, err_q;
    logic [15:0] flash_write_counter_q;     // nonvolatile write count
    logic [15:0] nv_gio_q;        // stored copies, reloaded on software reset
    logic [15:0] nv_misc_q;
    logic [15:0] nv_alarm_q;
    logic [15:0] nv_sleep_q;
    logic [15:0] rd_data_q;       // answer for the next frame
    logic        chk_fail_q;      // last checksum result
    logic        st_fail_q;       // last self test result

    // engine
    eng_t        state_q;
    logic [15:0] run_cnt_q;
    logic [3:0]  cmd_sel_q;       // one-hot: reset, flash, restore, bias
    logic        test_chk_q;      // running test is the checksum

    // link crossing
    logic [15:0] rx_word;
    logic        rx_toggle;
    logic        tog_meta_q, tog_sync_q, tog_last_q;
    logic [3:0]  din_meta_q, din_sync_q;

    // data ready
    logic [31:0] drdy_cnt_q;
    logic        drdy_act;

    // decoded frame
    sysctl_pkg::spi_frame_t frm;
    logic        frame_stb, wr_en, rd_en, hi_byte;
    logic [6:0]  reg_ofs;
    logic        cmd_done, test_done, soft_rst;
    logic [15:0] set_v;           // flag events in this cycle
    logic [3:0]  line_out, line_oe;

    // byte-lane write of a 16-bit register
    function automatic logic [15:0] put_byte(input logic [15:0] old,
                                             input logic        hi,
                                             input logic [7:0]  val);
        put_byte = hi ? {val, old[7:0]} : {old[15:8], val};
    endfunction

    spi_link_slave u_link (
        .sclk      (sclk),
        .rst_n     (rst_n),
        .cs_n      (cs_n),
        .mosi      (mosi),
        .tx_word   (rd_data_q),
        .miso      (miso),
        .miso_oe   (miso_oe),
        .rx_word   (rx_word),
        .rx_toggle (rx_toggle)
    );

    // frame toggle into clk; rx_word is steady once the toggle moved
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_meta_q <= 1'b0;
            tog_sync_q <= 1'b0;
            tog_last_q <= 1'b0;
        end else begin
            tog_meta_q <= rx_toggle;
            tog_sync_q <= tog_meta_q;
            tog_last_q <= tog_sync_q;
        end
    end

    // pin levels pass two flops before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            din_meta_q <= 4'h0;
            din_sync_q <= 4'h0;
        end else begin
            din_meta_q <= dio_in;
            din_sync_q <= din_meta_q;
        end
    end

    // frame decode
    always_comb begin
        frm       = rx_word;
        frame_stb = tog_sync_q ^ tog_last_q;
        wr_en     = frame_stb & frm.wr;
        rd_en     = frame_stb & ~frm.wr;
        hi_byte   = frm.addr[0];
        reg_ofs   = {frm.addr[6:1], 1'b0};
    end

    // engine completion strobes
    always_comb begin
        cmd_done  = (state_q == ST_CMD) &&
                    (run_cnt_q == 16'(sysctl_pkg::CMD_CYCLES - 1));
        test_done = (state_q == ST_TEST) &&
                    (run_cnt_q == 16'(sysctl_pkg::TEST_CYCLES - 1));
        soft_rst  = cmd_done & cmd_sel_q[3];
    end

    // engine: one function at a time, commands before tests
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            run_cnt_q  <= 16'h0000;
            cmd_sel_q  <= 4'h0;
            test_chk_q <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    run_cnt_q <= 16'h0000;
                    // software reset takes precedence over flash work
                    if (glob_q[sysctl_pkg::GC_SW_RESET]) begin
                        state_q   <= ST_CMD;
                        cmd_sel_q <= 4'h8;
                    end else if (glob_q[sysctl_pkg::GC_FLASH]) begin
                        state_q   <= ST_CMD;
                        cmd_sel_q <= 4'h4;
                    end else if (glob_q[sysctl_pkg::GC_RESTORE]) begin
                        state_q   <= ST_CMD;
                        cmd_sel_q <= 4'h2;
                    end else if (glob_q[sysctl_pkg::GC_BIAS]) begin
                        state_q   <= ST_CMD;
                        cmd_sel_q <= 4'h1;
                    end else if (misc_q[sysctl_pkg::MC_MEM_TEST]) begin
                        state_q    <= ST_TEST;
                        test_chk_q <= 1'b1;
                    end else if (misc_q[sysctl_pkg::MC_SELF_TEST]) begin
                        state_q    <= ST_TEST;
                        test_chk_q <= 1'b0;
                    end
                end
                ST_CMD, ST_TEST: begin
                    run_cnt_q <= run_cnt_q + 16'h0001;
                    if (cmd_done || test_done) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // global command: write one to start, cleared when done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            glob_q <= 16'h0000;
        end else if (soft_rst) begin
            glob_q <= 16'h0000;
        end else begin
            if (cmd_done) begin
                glob_q <= glob_q & ~{8'h00, cmd_sel_q[3], 3'h0,
                                     cmd_sel_q[2], 1'b0, cmd_sel_q[1:0]};
            end
            if (wr_en && reg_ofs == sysctl_pkg::OFS_GLOBAL_COMMAND) begin
                // a new trigger wins over a clear in the same cycle
                glob_q <= (cmd_done ? glob_q & ~{8'h00, cmd_sel_q[3], 3'h0,
                          cmd_sel_q[2], 1'b0, cmd_sel_q[1:0]} : glob_q)
                          | (put_byte(16'h0000, hi_byte, frm.data)
                          & sysctl_pkg::GC_MASK);
            end
        end
    end

    // flash write: stored copies, counter, and a pulse to the memory
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_gio_q    <= sysctl_pkg::GIO_RESET;
            nv_misc_q   <= sysctl_pkg::MC_RESET;
            nv_alarm_q  <= 16'h0000;
            nv_sleep_q  <= 16'h0000;
            flash_write_counter_q <= 16'h0000;
            flash_write <= 1'b0;
        end else begin
            flash_write <= cmd_done & (|cmd_sel_q[2:0]);
            if (cmd_done && cmd_sel_q[2:0] != 3'h0) begin
                flash_write_counter_q <= flash_write_counter_q + 16'h0001;
                nv_gio_q    <= gio_q;
                // triggers are never stored as set
                nv_misc_q   <= misc_q & ~16'h0c00;
                nv_alarm_q  <= alarm_q;
                nv_sleep_q  <= sleep_q;
            end
        end
    end

    // misc control; test bits self-clear, reload on software reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_q <= sysctl_pkg::MC_RESET;
        end else if (soft_rst) begin
            misc_q <= nv_misc_q;
        end else if (wr_en && reg_ofs == sysctl_pkg::OFS_MISC_CTRL) begin
            // reserved 9:8 are dropped by the mask, hosts must write zero
            misc_q <= put_byte(misc_q, hi_byte, frm.data)
                      & sysctl_pkg::MC_MASK;
        end else if (test_done && test_chk_q) begin
            misc_q[sysctl_pkg::MC_MEM_TEST] <= 1'b0;
        end else if (test_done) begin
            misc_q[sysctl_pkg::MC_SELF_TEST] <= 1'b0;
        end
    end

    // general I/O, alarm indicator and sleep registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gio_q   <= sysctl_pkg::GIO_RESET;
            alarm_q <= 16'h0000;
            sleep_q <= 16'h0000;
        end else if (soft_rst) begin
            gio_q   <= nv_gio_q;
            alarm_q <= nv_alarm_q;
            sleep_q <= nv_sleep_q;
        end else if (wr_en) begin
            if (reg_ofs == sysctl_pkg::OFS_GIO_CTRL) begin
                gio_q <= put_byte(gio_q, hi_byte, frm.data)
                         & sysctl_pkg::GIO_MASK;
            end
            if (reg_ofs == sysctl_pkg::OFS_ALARM_CTRL) begin
                alarm_q <= put_byte(alarm_q, hi_byte, frm.data)
                           & sysctl_pkg::AC_MASK;
            end
            if (reg_ofs == sysctl_pkg::OFS_SLEEP_CTRL) begin
                sleep_q <= put_byte(sleep_q, hi_byte, frm.data)
                           & sysctl_pkg::SLP_MASK;
            end
        end
    end

    // test results, kept so a failure reasserts every sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_fail_q <= 1'b0;
            st_fail_q  <= 1'b0;
        end else if (soft_rst) begin
            chk_fail_q <= 1'b0;
            st_fail_q  <= 1'b0;
        end else if (test_done && test_chk_q) begin
            chk_fail_q <= checksum_bad;
        end else if (test_done) begin
            st_fail_q <= self_test_bad;
        end
    end

    // flag events of this cycle; tests report at their own completion
    always_comb begin
        set_v = 16'h0000;
        if (sample_tick) begin
            set_v[sysctl_pkg::EF_ALARM2]    = alarm_status[1];
            set_v[sysctl_pkg::EF_ALARM1]    = alarm_status[0];
            set_v[sysctl_pkg::EF_OVERRANGE] = over_range;
            set_v[sysctl_pkg::EF_FLASH]     = flash_bad;
            set_v[sysctl_pkg::EF_CHECKSUM]  = chk_fail_q;
            set_v[sysctl_pkg::EF_SELF_TEST] = st_fail_q;
        end
        if (test_done && test_chk_q) begin
            set_v[sysctl_pkg::EF_CHECKSUM] = checksum_bad;
        end
        if (test_done && !test_chk_q) begin
            set_v[sysctl_pkg::EF_SELF_TEST] = self_test_bad;
        end
    end

    // error flags: cleared by a read, a new event wins over that read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 16'h0000;
        end else if (soft_rst) begin
            err_q <= 16'h0000;
        end else if (rd_en && reg_ofs == sysctl_pkg::OFS_ERR_FLAGS) begin
            err_q <= set_v;
        end else begin
            err_q <= err_q | set_v;
        end
    end

    // read answer, latched when a read frame lands
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 16'h0000;
        end else if (rd_en) begin
            unique case (reg_ofs)
                sysctl_pkg::OFS_FLASH_WRITE_COUNTER:  rd_data_q <= flash_write_counter_q;
                sysctl_pkg::OFS_ALARM_CTRL: rd_data_q <= alarm_q;
                // output lines read the set level, inputs read the pin
                sysctl_pkg::OFS_GIO_CTRL: begin
                    rd_data_q <= {4'h0,
                                  (gio_q[11:8] & line_oe) |
                                  (din_sync_q & ~line_oe),
                                  4'h0, gio_q[3:0]};
                end
                sysctl_pkg::OFS_MISC_CTRL:  rd_data_q <= misc_q;
                sysctl_pkg::OFS_SLEEP_CTRL: rd_data_q <= sleep_q;
                sysctl_pkg::OFS_ERR_FLAGS:  rd_data_q <= err_q;
                sysctl_pkg::OFS_GLOBAL_COMMAND:   rd_data_q <= glob_q;
                sysctl_pkg::OFS_LOT_ONE,
                sysctl_pkg::OFS_LOT_TWO,
                sysctl_pkg::OFS_LOT_THREE:  rd_data_q <= LOT_VALUE;
                sysctl_pkg::OFS_PART_CODE:  rd_data_q <= PART_VALUE;
                sysctl_pkg::OFS_SERIAL:     rd_data_q <= SER_VALUE;
                // unmapped addresses answer zero
                default:                    rd_data_q <= 16'h0000;
            endcase
        end
    end

    // data ready pulse: fixed length inside the 100 to 200 us window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drdy_cnt_q <= 32'h0000_0000;
        end else if (soft_rst) begin
            drdy_cnt_q <= 32'h0000_0000;
        end else if (sample_tick) begin
            drdy_cnt_q <= 32'(DRDY_LEN);
        end else if (drdy_cnt_q != 32'h0000_0000) begin
            drdy_cnt_q <= drdy_cnt_q - 32'h0000_0001;
        end
    end

    assign drdy_act = (drdy_cnt_q != 32'h0000_0000);

    // per-line ownership: data ready, then alarm, then general I/O
    for (genvar i = 0; i < 4; i++) begin : g_line
        logic dr_own, al_own;
        if (i < 2) begin : g_shared
            assign dr_own = misc_q[sysctl_pkg::MC_DR_EN] &&
                            (misc_q[sysctl_pkg::MC_DR_SEL] == 1'(i));
            assign al_own = alarm_q[sysctl_pkg::AC_EN] &&
                            (alarm_q[sysctl_pkg::AC_SEL] == 1'(i));
        end else begin : g_plain
            assign dr_own = 1'b0;
            assign al_own = 1'b0;
        end
        always_comb begin
            if (dr_own) begin
                line_oe[i]  = 1'b1;
                line_out[i] = ~(drdy_act ^ misc_q[sysctl_pkg::MC_DR_POL]);
            end else if (al_own) begin
                line_oe[i]  = 1'b1;
                line_out[i] = ~(alarm_active ^ alarm_q[sysctl_pkg::AC_POL]);
            end else begin
                line_oe[i]  = gio_q[sysctl_pkg::GIO_DIR + i];
                line_out[i] = gio_q[sysctl_pkg::GIO_LVL + i];
            end
        end
    end

    // line pins and control outputs, all from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dio_out         <= 4'h0;
            dio_oe          <= 4'h0;
            comp_bypass     <= 1'b0;
            self_test_drive <= 1'b0;
            data_clear      <= 1'b0;
        end else begin
            dio_out         <= line_out;
            dio_oe          <= line_oe;
            comp_bypass     <= misc_q[sysctl_pkg::MC_BYPASS];
            self_test_drive <= (state_q == ST_TEST) && !test_chk_q;
            // restore and reset both discard sensor data
            data_clear      <= cmd_done & (cmd_sel_q[3] | cmd_sel_q[1]);
        end
    end

endmodule // system_control_gpio

// ==== sysctl_properties.sv ====
// checker for the system control block, watching its outputs and the serial select input
// assumes it is bound to every system_control_gpio instance
`timescale 1ns/1ns
module sysctl_properties (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cs_n,
    input wire logic       miso_oe,
    input wire logic [3:0] dio_out,
    input wire logic [3:0] dio_oe,
    input wire logic       self_test_drive,
    input wire logic       flash_write,
    input wire logic       data_clear
);
    // one domain: all checks on the core clock, idle in reset
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_FLASH_GAP: assert property (flash_write |=> !flash_write [*8])
        else $error("flash write pulses too close");
    AST_CLEAR_PULSE: assert property (data_clear |=> !data_clear)
        else $error("data clear longer than one cycle");
    AST_ST_MIN: assert property ($rose(self_test_drive) |-> self_test_drive [*8])
        else $error("self test stimulus too short");
    AST_ST_MAX: assert property ($rose(self_test_drive) |-> ##[1:80] !self_test_drive)
        else $error("self test never finished");
    AST_ST_QUIET: assert property (self_test_drive |-> !flash_write)
        else $error("flash write during self test");
    AST_RST_QUIET: assert property ($rose(rst_n) |-> !flash_write && !data_clear)
        else $error("command action right after reset");
    AST_DIO_RESET: assert property ($rose(rst_n) |=> dio_oe == 4'h1 && !dio_out[0])
        else $error("line one not idle data ready after reset");
    // deselected port must let go of its output
    AST_MISO_IDLE: assert property (cs_n [*2] |-> !miso_oe)
        else $error("serial output driven while deselected");
endmodule // sysctl_properties

bind system_control_gpio sysctl_properties u_sysctl_properties (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .miso_oe(miso_oe), .dio_out(dio_out),
    .dio_oe(dio_oe), .self_test_drive(self_test_drive), .flash_write(flash_write),
    .data_clear(data_clear)
);

// ==== host_model.sv ====
// host model: serial master sending 16-bit frames
// assumes link clock idles high and data changes on its falling edge
`timescale 1ns/1ns
module host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    // idle bus at time zero
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // one frame at 160 ns per bit, msb first, answer taken on rising edges
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        #13 cs_n = 1'b0; // odd offset keeps the phase apart from the core clock
        for (int i = 15; i >= 0; i--) begin
            #40 sclk = 1'b0;
            mosi = w[i];
            #80 sclk = 1'b1;
            r[i] = miso;
            #40;
        end
        cs_n = 1'b1;
        mosi = ~mosi; // released line shows no stale value
        #200; // gap well above eight core cycles
    endtask
endmodule // host_model

// ==== tb_top.sv ====
// tb_top: self-checking bench for system_control_gpio
// assumes host_model as serial master and the bound checker
`timescale 1ns/1ns
module tb_top;
    logic        clk = 0, rst_n = 0, tick = 0, alm = 0, ck_bad = 0, st_bad = 0;
    wire         sclk, cs_n, mosi, miso, bypass, fw, clr;
    wire  [3:0]  dout, doe;
    logic [3:0]  ext = 4'h8; // far pins: line four held high
    wire  [3:0]  din = (doe & dout) | (~doe & ext);
    int          fail_count = 0, tests_run = 0, n_fw = 0, n_clr = 0, n;
    logic [15:0] r;
    // write frame, read address, expected register value
    logic [38:0] rows [9] = '{{16'hb8ff, 7'h1c, 16'h0006}, {16'h9a02, 7'h1a, 16'h0802},
        {16'h9b02, 7'h1a, 16'h0a02}, {16'h9a06, 7'h1a, 16'h0a06},
        {16'h9c87, 7'h1c, 16'h0087},
        {16'h9807, 7'h18, 16'h0007}, {16'hfe55, 7'h7e, 16'h0000},
        {16'ha800, 7'h28, 16'h0000}, {16'h0000, 7'h38, 16'h5a5a}};

    host_model u_host_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
    system_control_gpio #(.DRDY_LEN(20), .PART_VALUE(16'h5a5a)) u_system_control_gpio (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(), .dio_in(din), .dio_out(dout), .dio_oe(doe), .sample_tick(tick),
        .alarm_active(alm), .alarm_status(2'h0), .over_range(1'b0), .flash_bad(1'b0),
        .checksum_bad(ck_bad), .self_test_bad(st_bad), .comp_bypass(bypass),
        .self_test_drive(), .flash_write(fw), .data_clear(clr));

    always #4 clk = ~clk;
    // pulse counters for flash writes and data clears
    always @(posedge clk) begin
        n_fw  <= n_fw + int'(fw);
        n_clr <= n_clr + int'(clr);
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // read takes two frames: the answer comes in the second
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        u_host_model.xfer({1'b0, a, 8'h00}, r);
        u_host_model.xfer(16'h0000, r);
        chk(r, exp);
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
        foreach (rows[i]) begin
            u_host_model.xfer(rows[i][38:23], r);
            rd(rows[i][22:16], rows[i][15:0]);
        end
        @(negedge clk);
        alm = 1;
        repeat (4) @(negedge clk);
        chk(16'(bypass), 16'h0001);
        chk({8'h00, doe, dout}, 16'h0060);
        tick = 1;
        @(negedge clk) tick = 0;
        n = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge clk);
            n += int'(dout[1]);
        end
        chk(16'(n), 16'h0014);
        ck_bad = 1;
        st_bad = 1;
        u_host_model.xfer(16'ha808, r);
        u_host_model.xfer(16'h9d0c, r);
        repeat (300) @(negedge clk);
        chk(16'(n_fw), 16'h0001);
        rd(7'h00, 16'h0001);
        rd(7'h28, 16'h0000);
        rd(7'h1c, 16'h0087);
        rd(7'h26, 16'h0060);
        rd(7'h26, 16'h0000);
        u_host_model.xfer(16'ha803, r);
        u_host_model.xfer(16'h9c06, r);
        @(negedge clk);
        chk({8'h00, doe, dout}, 16'h0072);
        u_host_model.xfer(16'ha880, r);
        repeat (100) @(negedge clk);
        chk(16'(n_fw), 16'h0003);
        chk(16'(n_clr), 16'h0002);
        rd(7'h1c, 16'h0087);
        // mid-run pin reset: defaults return, line one idles low
        @(negedge clk) rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        chk({8'h00, doe, dout}, 16'h0010);
        rd(7'h1c, 16'h0006);
        tally_and_finish;
    end
endmodule // tb_top
